// >>> rtl/uamf_buf.sv
// Two-entry word buffer; read data always come from the head register
`timescale 1ns/1ps
`include "uamf_defines.svh"
module uamf_buf
	import uamf_pkg::*;
(
	// Clock and reset
	input  wire logic  clock,
	input  wire logic  rst,
	// Word stream
	uamf_buf_if.buffer bif
);
	uamf_buf_s st_reg;
	uamf_buf_s st_next;
	logic      push;
	logic      pop;

	assign bif.in_ready  = (st_reg.cnt != `UAMF_BUF_FULL);
	assign bif.out_valid = st_reg.ovld;
	assign bif.out_data  = st_reg.head;
	assign push          = bif.in_valid && bif.in_ready;
	assign pop           = bif.out_valid && bif.out_ready;

	always_comb begin
		st_next = st_reg;
		if (push && pop) begin
			if (st_reg.cnt == `UAMF_BUF_ONE) begin
				st_next.head = bif.in_data;
			end else begin
				st_next.head = st_reg.tail;
				st_next.tail = bif.in_data;
			end
		end else if (pop) begin
			st_next.head = st_reg.tail;
			st_next.cnt  = st_reg.cnt - `UAMF_BUF_ONE;
		end else if (push) begin
			if (st_reg.cnt == `UAMF_BUF_EMPTY) begin
				st_next.head = bif.in_data;
			end else begin
				st_next.tail = bif.in_data;
			end
			st_next.cnt = st_reg.cnt + `UAMF_BUF_ONE;
		end
		// Registered so the stream valid leaves the block straight from a flip-flop
		st_next.ovld = (st_next.cnt != `UAMF_BUF_EMPTY);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// A full buffer refuses words so the filter holds them pending
	chk_buf_full_refuse: assert property (@(posedge clock) disable iff (rst)
		st_reg.cnt == `UAMF_BUF_FULL && !bif.out_ready |=> st_reg.cnt == `UAMF_BUF_FULL)
		else $error("full buffer changed count without a pop");
endmodule

// >>> rtl/uamf_buf_if.sv
// Valid/ready carrier between the filter and its two-entry word buffer
`timescale 1ns/1ps
interface uamf_buf_if;
	import uamf_pkg::*;
	logic       in_valid;
	logic       in_ready;
	uamf_word_t in_data;
	logic       out_valid;
	logic       out_ready;
	uamf_word_t out_data;

	modport buffer (input in_valid, input in_data, input out_ready,
		output in_ready, output out_valid, output out_data);
	modport user (output in_valid, output in_data, output out_ready,
		input in_ready, input out_valid, input out_data);
endinterface

// >>> rtl/uamf_defines.svh
// Constants for the multidrop receive filter and serial interrupt ranking
`ifndef UAMF_DEFINES_SVH
`define UAMF_DEFINES_SVH

`define UAMF_PORTS      2
`define UAMF_DATA_W     8
`define UAMF_NINTH      8
`define UAMF_WORD_W     10
`define UAMF_BUF_DEPTH  2
`define UAMF_CNT_W      2
`define UAMF_BUF_EMPTY  2'h0
`define UAMF_BUF_ONE    2'h1
`define UAMF_BUF_FULL   2'h2

`define UAMF_MODE0      2'h0
`define UAMF_MODE1      2'h1
`define UAMF_MODE2      2'h2
`define UAMF_MODE3      2'h3

`define UAMF_ADDR_RST   8'h00
`define UAMF_DATA_ZERO  8'h00

`define UAMF_VEC_RX0    8'hA0
`define UAMF_VEC_TX0    8'hA4
`define UAMF_VEC_RX1    8'hA8
`define UAMF_VEC_TX1    8'hAC
`define UAMF_VEC_NONE   8'h00

`define UAMF_RANK_RX0   4'h7
`define UAMF_RANK_TX0   4'h8
`define UAMF_RANK_RX1   4'h9
`define UAMF_RANK_TX1   4'hA
`define UAMF_RANK_NONE  4'h0

`endif

// >>> rtl/uamf_pkg.sv
// Types shared by the multidrop receive filter modules
package uamf_pkg;
`include "uamf_defines.svh"

	typedef logic [`UAMF_WORD_W-1:0] uamf_word_t;

	typedef struct packed {
		logic [`UAMF_CNT_W-1:0] cnt;
		uamf_word_t             head;
		uamf_word_t             tail;
		logic                   ovld;
	} uamf_buf_s;

	typedef struct packed {
		logic [1:0]                    rxc;
		logic [1:0]                    ninth;
		logic [1:0]                    frm_err;
		logic [1:0]                    brk;
		logic [1:0]                    ovr;
		logic [1:0]                    txf;
		logic [1:0]                    pend;
		logic [1:0][`UAMF_DATA_W-1:0]  own_addr;
		logic [1:0][`UAMF_DATA_W-1:0]  smask;
		logic [1:0][`UAMF_WORD_W-1:0]  pword;
		logic                          irq_v;
		logic [7:0]                    vec;
		logic [3:0]                    rank;
	} uamf_top_s;
endpackage

// >>> rtl/uamf_top.sv
// Multidrop receive filter, error flags and serial interrupt ranking for two ports
// Functional notes
// R1: Port 0 rx vector A0H, tx A4H; port 1 rx A8H, tx ACH.
// R2: Equal-priority serial requests ranked 7,8,9,10; lowest rank served first.
// R3: Modes 2 and 3 capture nine bits; ninth goes to rx_ninth_bit.
// R4: Multiproc enable in modes 2/3: rx flag only when ninth bit is 1.
// R5: Master sends address frames with ninth bit 1, data with 0.
// R6: Multiproc enable ignored in mode 0.
// R7: Mode 1 with multiproc enable: rx flag only after valid stop bit.
// R8: Modes 2/3 with multiproc enable: rx flag only on given or broadcast match.
// R9: Only frames with ninth bit 1 are address candidates.
// R10: Given match compares only bits where the mask holds 1.
// R11: Broadcast is address OR mask; its zero bits are ignored.
// R12: Reset clears slave address and mask, disabling filtering.
// R13: Missing stop bit sets the port framing error flag; software clears.
// R14: All-zero character including stop sets the port break flag.
// R15: Bit 8 arriving while rx flag set sets the port overrun flag.
// R16: Match uses eight low data bits, evaluated at stop-bit sampling.
`timescale 1ns/1ps
`include "uamf_defines.svh"
module uamf_top
	import uamf_pkg::*;
(
	// Clock and reset
	input  wire logic                              clock,
	input  wire logic                              rst,
	// Receive and transmit shifter events, same clock domain
	input  wire logic [1:0]                        frame_done,
	input  wire logic [1:0][`UAMF_NINTH:0]         frame_bits,
	input  wire logic [1:0]                        stop_bit_level,
	input  wire logic [1:0]                        rx_bit8_stb,
	input  wire logic [1:0]                        tx_done,
	// Port configuration
	input  wire logic [1:0][1:0]                   rx_mode,
	input  wire logic [1:0]                        multiproc_enable,
	// Software writes and clears
	input  wire logic [1:0]                        slave_addr_wr,
	input  wire logic [1:0]                        slave_addr_mask_wr,
	input  wire logic [`UAMF_DATA_W-1:0]           wr_data,
	input  wire logic [1:0]                        rx_flag_clr,
	input  wire logic [1:0]                        tx_flag_clr,
	input  wire logic [1:0]                        err_flag_clr,
	// Flags and slave address registers
	output logic [1:0]                             rx_complete_flag,
	output logic [1:0]                             rx_ninth_bit,
	output logic [1:0]                             port_framing_error_flag,
	output logic [1:0]                             port_break_flag,
	output logic [1:0]                             port_overrun_flag,
	output logic [1:0]                             tx_done_flag,
	output logic [1:0][`UAMF_DATA_W-1:0]           slave_addr_reg,
	output logic [1:0][`UAMF_DATA_W-1:0]           slave_addr_mask_reg,
	// Interrupt requests and arbitration result
	output logic [3:0]                             irq_req,
	output logic                                   irq_pending,
	output logic [7:0]                             irq_vector,
	output logic [3:0]                             irq_rank,
	// Accepted word stream {port, ninth bit, data}
	output logic                                   rx_word_valid,
	input  wire logic                              rx_word_ready,
	output logic [`UAMF_WORD_W-1:0]                rx_word_data
);
	uamf_top_s st_reg;
	uamf_top_s st_next;
	uamf_buf_if bif ();

	function automatic logic is_nine(input logic [1:0] mode);
		is_nine = (mode == `UAMF_MODE2) || (mode == `UAMF_MODE3);
	endfunction

	// Given address and broadcast address, either one is a hit
	function automatic logic addr_match(input logic [7:0] d, input logic [7:0] sa,
		input logic [7:0] sm);
		logic [7:0] bc;
		bc = sa | sm; // R11
		addr_match = (((d ^ sa) & sm) == `UAMF_DATA_ZERO) // R10
			|| (((d ^ bc) & bc) == `UAMF_DATA_ZERO); // R11
	endfunction

	function automatic logic accept_frame(input logic [1:0] mode, input logic mpe,
		input logic stop, input logic [`UAMF_NINTH:0] bits, input logic [7:0] sa,
		input logic [7:0] sm);
		case (mode)
			`UAMF_MODE0: accept_frame = 1'b1; // R6
			`UAMF_MODE1: accept_frame = !mpe || stop; // R7
			default: accept_frame = !mpe || (bits[`UAMF_NINTH] // R4 R9
				&& addr_match(bits[`UAMF_DATA_W-1:0], sa, sm)); // R8 R16
		endcase
	endfunction

	uamf_buf u_buf (
		.clock (clock),
		.rst   (rst),
		.bif   (bif)
	);

	// Port 0 word goes first; a stalled buffer simply keeps words pending
	assign bif.in_valid  = |st_reg.pend;
	assign bif.in_data   = st_reg.pend[0] ? st_reg.pword[0] : st_reg.pword[1];
	assign bif.out_ready = rx_word_ready;

	always_comb begin
		st_next = st_reg;
		if (bif.in_ready) begin
			if (st_reg.pend[0]) begin
				st_next.pend[0] = 1'b0;
			end else if (st_reg.pend[1]) begin
				st_next.pend[1] = 1'b0;
			end
		end
		for (int p = 0; p < `UAMF_PORTS; p++) begin
			// Clears first so that a set in the same cycle wins
			if (rx_flag_clr[p]) begin
				st_next.rxc[p] = 1'b0;
			end
			if (tx_flag_clr[p]) begin
				st_next.txf[p] = 1'b0;
			end
			if (err_flag_clr[p]) begin
				st_next.frm_err[p] = 1'b0;
				st_next.brk[p] = 1'b0;
				st_next.ovr[p] = 1'b0;
			end
			if (slave_addr_wr[p]) begin
				st_next.own_addr[p] = wr_data;
			end
			if (slave_addr_mask_wr[p]) begin
				st_next.smask[p] = wr_data;
			end
			if (tx_done[p]) begin
				st_next.txf[p] = 1'b1;
			end
			if (rx_bit8_stb[p] && st_reg.rxc[p]) begin
				st_next.ovr[p] = 1'b1; // R15
			end
			if (frame_done[p]) begin
				if (is_nine(rx_mode[p])) begin
					st_next.ninth[p] = frame_bits[p][`UAMF_NINTH]; // R3
				end
				if (rx_mode[p] != `UAMF_MODE0 && !stop_bit_level[p]) begin
					st_next.frm_err[p] = 1'b1; // R13
					if (frame_bits[p][`UAMF_DATA_W-1:0] == `UAMF_DATA_ZERO
						&& !(is_nine(rx_mode[p]) && frame_bits[p][`UAMF_NINTH])) begin
						st_next.brk[p] = 1'b1; // R14
					end
				end
				if (accept_frame(rx_mode[p], multiproc_enable[p], stop_bit_level[p],
					frame_bits[p], st_reg.own_addr[p], st_reg.smask[p])) begin
					st_next.rxc[p]   = 1'b1; // R4 R8
					st_next.pend[p]  = 1'b1;
					st_next.pword[p] = {p[0], frame_bits[p]};
				end
			end
		end
		// Fixed order among equal-priority serial sources
		st_next.irq_v = |{st_reg.txf, st_reg.rxc};
		if (st_reg.rxc[0]) begin
			st_next.vec  = `UAMF_VEC_RX0; // R1
			st_next.rank = `UAMF_RANK_RX0; // R2
		end else if (st_reg.txf[0]) begin
			st_next.vec  = `UAMF_VEC_TX0; // R1
			st_next.rank = `UAMF_RANK_TX0; // R2
		end else if (st_reg.rxc[1]) begin
			st_next.vec  = `UAMF_VEC_RX1; // R1
			st_next.rank = `UAMF_RANK_RX1; // R2
		end else if (st_reg.txf[1]) begin
			st_next.vec  = `UAMF_VEC_TX1; // R1
			st_next.rank = `UAMF_RANK_TX1; // R2
		end else begin
			st_next.vec  = `UAMF_VEC_NONE;
			st_next.rank = `UAMF_RANK_NONE;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			// Zero address and mask make every bit a don't-care
			st_reg <= '0; // R12
		end else begin
			st_reg <= st_next;
		end
	end

	assign rx_complete_flag        = st_reg.rxc;
	assign rx_ninth_bit            = st_reg.ninth;
	assign port_framing_error_flag = st_reg.frm_err;
	assign port_break_flag         = st_reg.brk;
	assign port_overrun_flag       = st_reg.ovr;
	assign tx_done_flag            = st_reg.txf;
	assign slave_addr_reg          = st_reg.own_addr;
	assign slave_addr_mask_reg     = st_reg.smask;
	assign irq_req                 = {st_reg.txf[1], st_reg.rxc[1], st_reg.txf[0], st_reg.rxc[0]};
	assign irq_pending             = st_reg.irq_v;
	assign irq_vector              = st_reg.vec;
	assign irq_rank                = st_reg.rank;
	assign rx_word_valid           = bif.out_valid;
	assign rx_word_data            = bif.out_data;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_p0_nine_mp;
		frame_done[0] && is_nine(rx_mode[0]) && multiproc_enable[0] && !st_reg.rxc[0];
	endsequence

	sequence s_p0_idle_flag;
		!st_reg.rxc[0] && !rx_flag_clr[0];
	endsequence

	chk_rx0_vector_first: assert property ( // R1
		st_reg.rxc[0] |=> irq_pending && irq_vector == `UAMF_VEC_RX0
			&& irq_rank == `UAMF_RANK_RX0)
		else $error("port 0 receive not served first at its vector");

	chk_arb_rank_order: assert property ( // R2
		!st_reg.rxc[0] && st_reg.txf[0] && st_reg.rxc[1]
			|=> irq_vector == `UAMF_VEC_TX0 && irq_rank == `UAMF_RANK_TX0)
		else $error("port 0 transmit did not outrank port 1 receive");

	chk_ninth_capture: assert property ( // R3
		frame_done[0] && is_nine(rx_mode[0])
			|=> rx_ninth_bit[0] == $past(frame_bits[0][`UAMF_NINTH]))
		else $error("ninth bit not captured");

	chk_data_frame_drop: assert property ( // R4
		s_p0_nine_mp ##0 !frame_bits[0][`UAMF_NINTH] |=> s_p0_idle_flag ##0 !rx_word_valid
			or !rx_complete_flag[0])
		else $error("data frame raised receive flag under multiproc enable");

	chk_mode0_ignores_mp: assert property ( // R6
		frame_done[0] && rx_mode[0] == `UAMF_MODE0 |=> rx_complete_flag[0] ##1 irq_pending)
		else $error("mode 0 frame not accepted");

	chk_mode1_stop_gate: assert property ( // R7
		frame_done[0] && rx_mode[0] == `UAMF_MODE1 && multiproc_enable[0]
			&& !stop_bit_level[0] && !st_reg.rxc[0] |=> !rx_complete_flag[0])
		else $error("mode 1 frame without stop bit accepted");

	chk_addr_match_gate: assert property ( // R8
		s_p0_nine_mp ##0 frame_bits[0][`UAMF_NINTH]
			|=> rx_complete_flag[0] == $past(addr_match(frame_bits[0][`UAMF_DATA_W-1:0],
				st_reg.own_addr[0], st_reg.smask[0])))
		else $error("address match did not decide the receive flag");

	chk_reset_addr_clear: assert property ( // R12
		$fell(rst) |-> slave_addr_reg[0] == `UAMF_ADDR_RST
			&& slave_addr_mask_reg[0] == `UAMF_ADDR_RST)
		else $error("slave address not cleared by reset");

	chk_framing_set: assert property ( // R13
		frame_done[1] && rx_mode[1] != `UAMF_MODE0 && !stop_bit_level[1]
			|=> port_framing_error_flag[1])
		else $error("framing error not flagged");

	chk_overrun_set: assert property ( // R15
		rx_bit8_stb[0] && st_reg.rxc[0] |=> port_overrun_flag[0] [*2] or err_flag_clr[0])
		else $error("overrun not flagged");

	chk_overrun_needs_flag: assert property ( // R15
		rx_bit8_stb[1] && !st_reg.rxc[1] && !st_reg.ovr[1] |=> !port_overrun_flag[1])
		else $error("overrun flagged with receive flag clear");

	sequence s_p0_addr_frame;
		s_p0_nine_mp ##0 frame_bits[0][`UAMF_NINTH];
	endsequence

	chk_given_addr_hit: assert property ( // R10
		s_p0_addr_frame ##0 ((frame_bits[0][`UAMF_DATA_W-1:0] ^ st_reg.own_addr[0])
			& st_reg.smask[0]) == `UAMF_DATA_ZERO |=> rx_complete_flag[0])
		else $error("given address match did not set the receive flag");

	chk_bcast_addr_hit: assert property ( // R11
		s_p0_addr_frame ##0 (frame_bits[0][`UAMF_DATA_W-1:0]
			& (st_reg.own_addr[0] | st_reg.smask[0]))
			== (st_reg.own_addr[0] | st_reg.smask[0]) |=> rx_complete_flag[0])
		else $error("broadcast address match did not set the receive flag");

	chk_reset_accepts_addr: assert property ( // R12
		s_p0_addr_frame ##0 st_reg.own_addr[0] == `UAMF_ADDR_RST
			&& st_reg.smask[0] == `UAMF_ADDR_RST |=> st_reg.pend[0]
			&& st_reg.pword[0] == {1'b0, $past(frame_bits[0])})
		else $error("address frame refused with cleared address and mask");

	chk_break_all_zero: assert property ( // R14
		frame_done[0] && rx_mode[0] == `UAMF_MODE1 && !stop_bit_level[0]
			&& frame_bits[0][`UAMF_DATA_W-1:0] == `UAMF_DATA_ZERO |=> port_break_flag[0])
		else $error("all-zero character did not set the break flag");

	chk_break_needs_stop: assert property ( // R14
		frame_done[0] && stop_bit_level[0] && !st_reg.brk[0] |=> !port_break_flag[0])
		else $error("break flag set although the stop bit was high");

	chk_framing_port0: assert property ( // R13
		frame_done[0] && rx_mode[0] != `UAMF_MODE0 && !stop_bit_level[0]
			|=> port_framing_error_flag[0])
		else $error("port 0 framing error not flagged");

	chk_ninth_kept: assert property ( // R3
		frame_done[0] && !is_nine(rx_mode[0]) |=> $stable(rx_ninth_bit[0]))
		else $error("ninth bit changed outside nine-bit modes");

	chk_tx1_vector_last: assert property ( // R1
		!st_reg.rxc[0] && !st_reg.txf[0] && !st_reg.rxc[1] && st_reg.txf[1]
			|=> irq_vector == `UAMF_VEC_TX1 && irq_rank == `UAMF_RANK_TX1)
		else $error("port 1 transmit not raised at its vector");

	chk_idle_no_request: assert property ( // R2
		st_reg.rxc == '0 && st_reg.txf == '0
			|=> !irq_pending && irq_rank == `UAMF_RANK_NONE)
		else $error("interrupt pending with no serial source set");
endmodule

// >>> test/test_uamf_top.sv
// Self-checking bench for the multidrop receive filter
`timescale 1ns/1ps
module test_uamf_top;
	import uamf_pkg::*;

	typedef struct packed {
		logic [1:0] m;
		logic       e;
		logic [8:0] b;
		logic       s;
		logic [2:0] x;
	} uamf_case_s;

	logic clock, rst;
	logic [1:0] frame_done, stop_bit_level, rx_bit8_stb, tx_done, multiproc_enable;
	logic [1:0][8:0] frame_bits;
	logic [1:0][1:0] rx_mode;
	logic [1:0] slave_addr_wr, slave_addr_mask_wr, rx_flag_clr, tx_flag_clr, err_flag_clr;
	logic [7:0] wr_data, irq_vector;
	logic [1:0] rxc, ninth, ferr, brk, ovr, txf;
	logic [1:0][7:0] sa, sm;
	logic [3:0] irq_req, irq_rank;
	logic irq_pending, rx_word_valid, rx_word_ready;
	logic [9:0] rx_word_data;
	logic [9:0] got[$];
	int failures, comparisons;
	uamf_case_s cases[12] = '{16'hBC0C, 16'hBC2C, 16'hBC18, 16'hFFDC, 16'hFFFC, 16'hEC08,
		16'hDC1C, 16'h6C02, 16'h6C0C, 16'h4007, 16'h2C1C, 16'hBC12};
	logic [7:0] vecs[5] = '{8'hA0, 8'hA4, 8'hA8, 8'hAC, 8'h00};
	logic [3:0] rks[5] = '{4'h7, 4'h8, 4'h9, 4'hA, 4'h0};

	uamf_node_model uamf_node_model_i (.clock(clock), .frame_done(frame_done),
		.frame_bits(frame_bits), .stop_bit_level(stop_bit_level));

	uamf_top uamf_top_i (.clock(clock), .rst(rst), .frame_done(frame_done),
		.frame_bits(frame_bits), .stop_bit_level(stop_bit_level), .rx_bit8_stb(rx_bit8_stb),
		.tx_done(tx_done), .rx_mode(rx_mode), .multiproc_enable(multiproc_enable),
		.slave_addr_wr(slave_addr_wr), .slave_addr_mask_wr(slave_addr_mask_wr),
		.wr_data(wr_data), .rx_flag_clr(rx_flag_clr), .tx_flag_clr(tx_flag_clr),
		.err_flag_clr(err_flag_clr), .rx_complete_flag(rxc), .rx_ninth_bit(ninth),
		.port_framing_error_flag(ferr), .port_break_flag(brk), .port_overrun_flag(ovr),
		.tx_done_flag(txf), .slave_addr_reg(sa), .slave_addr_mask_reg(sm),
		.irq_req(irq_req), .irq_pending(irq_pending), .irq_vector(irq_vector),
		.irq_rank(irq_rank), .rx_word_valid(rx_word_valid), .rx_word_ready(rx_word_ready),
		.rx_word_data(rx_word_data));

	always #2.5 clock = ~clock;

	always @(posedge clock) begin
		if (rx_word_valid && rx_word_ready) begin
			got.push_back(rx_word_data);
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// Clear strobes: src is {tx1,rx1,tx0,rx0}, err per port
	task automatic clr(input logic [3:0] src, input logic [1:0] err);
		@(negedge clock);
		rx_flag_clr  = {src[2], src[0]};
		tx_flag_clr  = {src[3], src[1]};
		err_flag_clr = err;
		@(negedge clock);
		rx_flag_clr  = 2'h0;
		tx_flag_clr  = 2'h0;
		err_flag_clr = 2'h0;
	endtask

	task automatic test_done;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge clock);
		failures++;
		test_done;
	end

	initial begin
		clock = 1'b0; rst = 1'b1; rx_bit8_stb = 2'h0; tx_done = 2'h0; rx_mode = 4'h0;
		multiproc_enable = 2'h0; slave_addr_wr = 2'h0; slave_addr_mask_wr = 2'h0;
		wr_data = 8'h00; rx_flag_clr = 2'h0; tx_flag_clr = 2'h0; err_flag_clr = 2'h0;
		rx_word_ready = 1'b1;
		repeat (8) @(negedge clock);
		rst = 1'b0;
		chk({sa, sm}, 32'h0);
		rx_mode = 4'hA;
		multiproc_enable = 2'h3;
		uamf_node_model_i.send(2'h1, 9'h137, 1'b1);
		@(negedge clock);
		chk(rxc[0], 1'b1);
		wr_data = 8'hC0; slave_addr_wr = 2'h1;
		@(negedge clock);
		slave_addr_wr = 2'h0; wr_data = 8'hFD; slave_addr_mask_wr = 2'h1;
		@(negedge clock);
		slave_addr_mask_wr = 2'h0;
		chk({sa[0], sm[0]}, 16'hC0FD);
		$display("test reset and address setup done");

		// Filter table on port 0 with address C0, mask FD
		foreach (cases[i]) begin
			clr(4'h5, 2'h3);
			rx_mode[0] = cases[i].m;
			multiproc_enable[0] = cases[i].e;
			uamf_node_model_i.send(2'h1, cases[i].b, cases[i].s);
			@(negedge clock);
			chk({rxc[0], ferr[0], brk[0]}, cases[i].x);
			chk(irq_req[0], cases[i].x[2]);
			if (cases[i].m[1] && cases[i].x[2]) chk(ninth[0], cases[i].b[8]);
		end
		$display("test filter table done");

		// Four pending sources retire in rank order
		clr(4'h5, 2'h3);
		rx_mode = 4'h0;
		multiproc_enable = 2'h0;
		tx_done = 2'h3;
		@(negedge clock);
		tx_done = 2'h0;
		uamf_node_model_i.send(2'h3, 9'h055, 1'b1);
		repeat (3) @(negedge clock);
		chk(irq_req, 4'hF);
		for (int i = 0; i < 5; i++) begin
			chk({irq_pending, irq_vector, irq_rank}, {i < 4, vecs[i], rks[i]});
			if (i < 4) clr(4'h1 << i, 2'h0);
			repeat (2) @(negedge clock);
		end
		$display("test interrupt ranking done");

		// Bit 8 arriving over a set flag only hits that port
		uamf_node_model_i.send(2'h1, 9'h033, 1'b1);
		rx_bit8_stb = 2'h3;
		@(negedge clock);
		rx_bit8_stb = 2'h0;
		@(negedge clock);
		chk(ovr, 2'h1);
		clr(4'h1, 2'h3);
		@(negedge clock);
		chk(ovr, 2'h0);
		$display("test overrun done");

		// Port 1 all-zero frame with a low stop bit leaves port 0 untouched
		rx_mode[1] = 2'h1;
		uamf_node_model_i.send(2'h2, 9'h000, 1'b0);
		@(negedge clock);
		chk({ferr[1], brk[1], rxc[1], ferr[0]}, 4'hE);
		clr(4'h4, 2'h2);
		$display("test port 1 break done");

		// Receiver stalls while three accepted addresses arrive
		rx_mode[0] = 2'h2;
		multiproc_enable[0] = 1'b1;
		repeat (4) @(negedge clock);
		rx_word_ready = 1'b0;
		got.delete();
		uamf_node_model_i.send(2'h1, uamf_node_model_i.frame_of(1'b1, 8'hC0), 1'b1);
		uamf_node_model_i.send(2'h1, uamf_node_model_i.frame_of(1'b1, 8'hFF), 1'b1);
		uamf_node_model_i.send(2'h1, uamf_node_model_i.frame_of(1'b1, 8'hC2), 1'b1);
		repeat (4) @(negedge clock);
		chk({rx_word_valid, got.size() == 0}, 2'h3);
		rx_word_ready = 1'b1;
		repeat (8) @(negedge clock);
		chk(got.size(), 3);
		chk({got[0], got[1], got[2]}, {10'h1C0, 10'h1FF, 10'h1C2});
		chk(rx_word_valid, 1'b0);
		$display("test word buffer done");
		test_done;
	end
endmodule

// >>> test/uamf_node_model.sv
// Far-side serial node model that hands finished frames to the filter
`timescale 1ns/1ps
module uamf_node_model (
	// Clock
	input  wire logic       clock,
	// Frame events toward the filter
	output logic [1:0]      frame_done,
	output logic [1:0][8:0] frame_bits,
	output logic [1:0]      stop_bit_level
);
	initial begin
		frame_done     = 2'h0;
		frame_bits     = 18'h00000;
		stop_bit_level = 2'h0;
	end

	// Address frames carry a ninth bit of 1, data frames a ninth bit of 0
	function automatic logic [8:0] frame_of(input logic is_addr, input logic [7:0] d);
		return {is_addr, d};
	endfunction

	// Fields flip once the pulse is gone, so a stale frame can never pass for a fresh one
	task automatic send(input logic [1:0] pm, input logic [8:0] b, input logic s);
		@(negedge clock);
		for (int p = 0; p < 2; p++) begin
			if (pm[p]) begin
				frame_bits[p]     = b;
				stop_bit_level[p] = s;
			end
		end
		frame_done = pm;
		@(negedge clock);
		frame_done = 2'h0;
		for (int p = 0; p < 2; p++) begin
			if (pm[p]) begin
				frame_bits[p]     = ~b;
				stop_bit_level[p] = ~s;
			end
		end
	endtask
endmodule
